// ===== design/timer16_ctc_fast_pwm.sv
/*
  16-bit timer with clear-on-match counting and single-slope fast PWM, two compare outputs.
  Assumes a synchronous software master on the register port and pins taken in as synchronous.
*/
// Behaviour
// - Mode 4 clears count at compare A match, mode 12 at capture-top match.
// - Clear-on-match top is unbuffered; missed top runs count through 0xFFFF.
// - Clear-on-match with action 1 toggles output A on each match.
// - Wave output reaches pin only while its direction bit is one.
// - Clear-on-match raises overflow flag when count rolls from max to zero.
// - Clear-on-match sets compare A or capture flag when count reaches top.
// - Fast modes 5, 6, 7 use tops 0x00FF, 0x01FF, 0x03FF; clear after top.
// - Fast mode 14 takes top from capture-top, 15 from compare A.
// - Fast action 2 clears on match, sets at bottom; 3 is inverted.
// - Fast mode sets overflow at top, plus top register flag same cycle.
// - A compare flag sets on each counting tick with count equal to that compare value, unless a count write blocks it.
// - Fixed top masks unused compare bits whenever a compare register is written.
// - Fast mode capture-top unbuffered; value below count wraps through 0xFFFF.
// - Fast mode buffers compare writes, loaded at top with clear and overflow.
// - Compare zero gives one-cycle spike; compare equal top gives constant level.
// - Fast mode 15 with action 1 toggles output A for 50% duty.
// - Timer tick is clock divided by 1, 8, 64, 256 or 1024.
// - Fast PWM period is prescale times top plus one clocks.
// - Action 0 leaves the wave output unchanged on match in every mode.
// - A write to the count blocks all compare matches in the next tick.
`timescale 1ns/1ns
`include "timer16_regs.svh"

module timer16_ctc_fast_pwm
  import timer16_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [15:0] o_rdata,
  output logic [1:0] o_wave_out,
  output logic [1:0] o_wave_out_en,
  output logic [3:0] o_flags
);

  bus_req_t bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, write: i_write, read: i_read};

  logic [15:0] control_reg;
  logic [15:0] count_value_reg;
  logic [15:0] compare_a_value_reg;
  logic [15:0] compare_b_value_reg;
  logic [15:0] compare_a_buf_reg;
  logic [15:0] compare_b_buf_reg;
  logic [15:0] capture_top_value_reg;
  logic [3:0] flags_reg;
  logic [1:0] wave_out_reg;
  logic [15:0] rdata_reg;
  logic [9:0] prescale_reg;
  logic block_reg;
  logic [1:0] wave_pin_reg;
  logic [1:0] wave_en_reg;

  wire mode_t waveform_mode_select = mode_t'(control_reg[`CTRL_MODE_LSB +: 4]);
  wire clock_sel_t clock_select = clock_sel_t'(control_reg[`CTRL_CLKSEL_LSB +: 3]);
  wire [1:0] output_a_action_select = control_reg[`CTRL_ACT_A_LSB +: 2];
  wire [1:0] output_b_action_select = control_reg[`CTRL_ACT_B_LSB +: 2];
  wire [1:0] pin_direction = {control_reg[`CTRL_DIR_B_BIT], control_reg[`CTRL_DIR_A_BIT]};

  wire is_ctc = (waveform_mode_select == MODE_CTC_CMPA) || (waveform_mode_select == MODE_CTC_CAPT);
  wire is_fast = (waveform_mode_select == MODE_FAST_8) || (waveform_mode_select == MODE_FAST_9) ||
                 (waveform_mode_select == MODE_FAST_10) ||
                 (waveform_mode_select == MODE_FAST_CAPT) ||
                 (waveform_mode_select == MODE_FAST_CMPA);
  wire top_is_cmpa = (waveform_mode_select == MODE_CTC_CMPA) ||
                     (waveform_mode_select == MODE_FAST_CMPA);
  wire top_is_capt = (waveform_mode_select == MODE_CTC_CAPT) ||
                     (waveform_mode_select == MODE_FAST_CAPT);

  logic [15:0] top_value;
  always_comb begin
    case (waveform_mode_select)
      MODE_FAST_8: top_value = `TOP_8BIT;
      MODE_FAST_9: top_value = `TOP_9BIT;
      MODE_FAST_10: top_value = `TOP_10BIT;
      MODE_CTC_CMPA, MODE_FAST_CMPA: top_value = compare_a_value_reg;
      MODE_CTC_CAPT, MODE_FAST_CAPT: top_value = capture_top_value_reg;
      default: top_value = `COUNT_MAX;
    endcase
  end
  wire [15:0] fixed_mask = (waveform_mode_select == MODE_FAST_8) ? `TOP_8BIT :
                           (waveform_mode_select == MODE_FAST_9) ? `TOP_9BIT :
                           (waveform_mode_select == MODE_FAST_10) ? `TOP_10BIT : `COUNT_MAX;

  logic [9:0] prescale_limit;
  always_comb begin
    case (clock_select)
      CLK_DIV8: prescale_limit = `DIV_8;
      CLK_DIV64: prescale_limit = `DIV_64;
      CLK_DIV256: prescale_limit = `DIV_256;
      CLK_DIV1024: prescale_limit = `DIV_1024;
      default: prescale_limit = 10'h000;
    endcase
  end
  wire clock_run = (clock_select != CLK_STOP) && (clock_select <= CLK_DIV1024);
  wire tick = clock_run && (prescale_reg >= prescale_limit);
  // only the two supported families count
  wire active = is_ctc || is_fast;

  wire wr_control = bus.write && (bus.addr == `ADDR_CONTROL);
  wire wr_count = bus.write && (bus.addr == `ADDR_COUNT);
  wire wr_cmpa = bus.write && (bus.addr == `ADDR_COMPARE_A);
  wire wr_cmpb = bus.write && (bus.addr == `ADDR_COMPARE_B);
  wire wr_capt = bus.write && (bus.addr == `ADDR_CAPTURE_TOP);
  wire wr_flags = bus.write && (bus.addr == `ADDR_FLAGS);
  wire wr_wave = bus.write && (bus.addr == `ADDR_WAVE);

  wire at_top = (count_value_reg == top_value);
  wire at_max = (count_value_reg == `COUNT_MAX);
  wire match_ok = tick && active && !block_reg;
  wire top_match = match_ok && at_top;
  wire [1:0] cmp_match = {match_ok && (count_value_reg == compare_b_value_reg),
                          match_ok && (count_value_reg == compare_a_value_reg)};
  // unbuffered top missed, run to max
  wire [15:0] count_next = (tick && active && at_top) ? `COUNT_BOTTOM : count_value_reg + 16'h0001;
  // A top of 0xFFFF also rolls from max to zero, so overflow must not depend on the top
  wire roll_max = tick && active && at_max;
  wire cleared = tick && active && at_top;

  wire ovf_event = (is_ctc && roll_max) || (is_fast && top_match);
  wire [3:0] flag_set = {top_is_capt && top_match, cmp_match[1], cmp_match[0], ovf_event};

  wire [1:0] action [2];
  assign action[0] = output_a_action_select;
  assign action[1] = output_b_action_select;

  // Per-channel waveform; action 0 holds the output
  logic [1:0] wave_next;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_wave
      always_comb begin
        wave_next[ch] = wave_out_reg[ch];
        if (is_ctc && cmp_match[ch] && action[ch] == 2'h1 && ch == 0) begin
          wave_next[ch] = ~wave_out_reg[ch];
        end else if (is_fast && action[ch] == 2'h1) begin
          // toggle only with compare A as top
          if (ch == 0 && waveform_mode_select == MODE_FAST_CMPA && cmp_match[ch]) begin
            wave_next[ch] = ~wave_out_reg[ch];
          end
        end else if (is_fast && action[ch][1]) begin
          // match beats bottom reset so top compare stays constant
          if (cmp_match[ch]) begin
            wave_next[ch] = action[ch][0];
          end else if (cleared) begin
            wave_next[ch] = ~action[ch][0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prescale_reg <= 10'h000;
    end else if (!clock_run || tick) begin
      prescale_reg <= 10'h000;
    end else begin
      prescale_reg <= prescale_reg + 10'h001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_value_reg <= `COUNT_BOTTOM;
      block_reg <= 1'b0;
    end else if (wr_count) begin
      count_value_reg <= bus.wdata;
      block_reg <= 1'b1;
    end else begin
      if (tick && active) begin
        count_value_reg <= count_next;
      end
      if (tick) begin
        block_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      control_reg <= `CONTROL_RESET;
      capture_top_value_reg <= `COUNT_BOTTOM;
    end else begin
      if (wr_control) begin
        control_reg <= bus.wdata;
      end
      if (wr_capt) begin
        capture_top_value_reg <= bus.wdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      compare_a_buf_reg <= `COUNT_BOTTOM;
      compare_b_buf_reg <= `COUNT_BOTTOM;
      compare_a_value_reg <= `COUNT_BOTTOM;
      compare_b_value_reg <= `COUNT_BOTTOM;
    end else begin
      if (wr_cmpa) begin
        compare_a_buf_reg <= bus.wdata & fixed_mask;
      end
      if (wr_cmpb) begin
        compare_b_buf_reg <= bus.wdata & fixed_mask;
      end
      if (!is_fast) begin
        if (wr_cmpa) begin
          compare_a_value_reg <= bus.wdata & fixed_mask;
        end
        if (wr_cmpb) begin
          compare_b_value_reg <= bus.wdata & fixed_mask;
        end
      end else if (cleared) begin
        compare_a_value_reg <= compare_a_buf_reg;
        compare_b_value_reg <= compare_b_buf_reg;
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flags_reg <= 4'h0;
    end else begin
      flags_reg <= (flags_reg & ~(wr_flags ? bus.wdata[3:0] : 4'h0)) | flag_set;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wave_out_reg <= 2'h0;
    end else if (wr_wave) begin
      wave_out_reg <= bus.wdata[1:0];
    end else begin
      wave_out_reg <= wave_next;
    end
  end

  // Pin follows a forced state in the same cycle as the internal state
  wire [1:0] wave_load = wr_wave ? bus.wdata[1:0] : wave_next;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wave_pin_reg <= 2'h0;
      wave_en_reg <= 2'h0;
    end else begin
      wave_pin_reg <= wave_load & pin_direction;
      wave_en_reg <= pin_direction;
    end
  end

  logic [15:0] read_mux;
  always_comb begin
    case (bus.addr)
      `ADDR_CONTROL: read_mux = control_reg;
      `ADDR_COUNT: read_mux = count_value_reg;
      `ADDR_COMPARE_A: read_mux = is_fast ? compare_a_buf_reg : compare_a_value_reg;
      `ADDR_COMPARE_B: read_mux = is_fast ? compare_b_buf_reg : compare_b_value_reg;
      `ADDR_CAPTURE_TOP: read_mux = capture_top_value_reg;
      `ADDR_FLAGS: read_mux = {12'h000, flags_reg};
      `ADDR_WAVE: read_mux = {14'h0000, wave_out_reg};
      default: read_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= bus.read ? read_mux : 16'h0000;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_wave_out = wave_pin_reg;
  assign o_wave_out_en = wave_en_reg;
  assign o_flags = flags_reg;

  chk_top_clears: assert property (@(posedge i_clock) disable iff (i_rst)
    (tick && active && at_top && !wr_count) |=> count_value_reg == `COUNT_BOTTOM)
    else $error("count not cleared after top");
  chk_wrap_max: assert property (@(posedge i_clock) disable iff (i_rst)
    (tick && active && at_max && !at_top && !wr_count) |=> count_value_reg == `COUNT_BOTTOM)
    else $error("count did not wrap at max");
  chk_ctc_ovf: assert property (@(posedge i_clock) disable iff (i_rst)
    (is_ctc && tick && at_max && !at_top) |=> flags_reg[`FLAG_OVF_BIT])
    else $error("overflow flag missing at roll");
  chk_fast_ovf: assert property (@(posedge i_clock) disable iff (i_rst)
    (is_fast && top_match) |=> flags_reg[`FLAG_OVF_BIT] && (!top_is_cmpa || flags_reg[1]))
    else $error("fast top flags missing");
  chk_cmp_flag: assert property (@(posedge i_clock) disable iff (i_rst)
    cmp_match[0] |=> flags_reg[`FLAG_CMPA_BIT])
    else $error("compare flag not set");
  chk_block_write: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_count |=> !cmp_match[0] && !cmp_match[1])
    else $error("match not blocked after count write");
  chk_buf_load: assert property (@(posedge i_clock) disable iff (i_rst)
    (is_fast && cleared && !wr_control) |=> compare_a_value_reg == $past(compare_a_buf_reg))
    else $error("compare buffer not loaded");
  chk_pin_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    !pin_direction[0] |=> !o_wave_out[0])
    else $error("pin driven without direction");
  chk_hold_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    (output_a_action_select == 2'h0 && !wr_wave) |=> $stable(wave_out_reg[0]))
    else $error("output changed with action zero");
  chk_ctc_toggle: assert property (@(posedge i_clock) disable iff (i_rst)
    (is_ctc && cmp_match[0] && output_a_action_select == 2'h1 && !wr_wave)
    |=> wave_out_reg[0] != $past(wave_out_reg[0]))
    else $error("output A not toggled on match");
  chk_fast_bottom: assert property (@(posedge i_clock) disable iff (i_rst)
    (is_fast && cleared && !cmp_match[0] && output_a_action_select == 2'h2 && !wr_wave)
    |=> wave_out_reg[0])
    else $error("output A not set at bottom");

endmodule

// ===== design/timer16_regs.svh
/*
  Register map, field positions, reset values and timing constants of the 16-bit waveform timer.
  Assumes a plain register port with one-cycle strobes and read data one cycle later.
*/
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

`define ADDR_CONTROL 4'h0
`define ADDR_COUNT 4'h1
`define ADDR_COMPARE_A 4'h2
`define ADDR_COMPARE_B 4'h3
`define ADDR_CAPTURE_TOP 4'h4
`define ADDR_FLAGS 4'h5
`define ADDR_WAVE 4'h6

`define CTRL_MODE_LSB 0
`define CTRL_CLKSEL_LSB 4
`define CTRL_ACT_A_LSB 8
`define CTRL_ACT_B_LSB 10
`define CTRL_DIR_A_BIT 12
`define CTRL_DIR_B_BIT 13

`define FLAG_OVF_BIT 0
`define FLAG_CMPA_BIT 1
`define FLAG_CMPB_BIT 2
`define FLAG_CAPT_BIT 3

`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define COUNT_MAX 16'hFFFF
`define COUNT_BOTTOM 16'h0000
`define CONTROL_RESET 16'h0000

`define DIV_8 10'h007
`define DIV_64 10'h03F
`define DIV_256 10'h0FF
`define DIV_1024 10'h3FF

`endif

// ===== design/timer16_pkg.sv
/*
  Types of the 16-bit waveform timer: mode codes, clock selects and the register bus carrier.
  Assumes the constants header supplies offsets and field positions.
*/
package timer16_pkg;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h0,
    MODE_CTC_CMPA = 4'h4,
    MODE_FAST_8 = 4'h5,
    MODE_FAST_9 = 4'h6,
    MODE_FAST_10 = 4'h7,
    MODE_CTC_CAPT = 4'hC,
    MODE_FAST_CAPT = 4'hE,
    MODE_FAST_CMPA = 4'hF
  } mode_t;

  typedef enum logic [2:0] {
    CLK_STOP = 3'h0,
    CLK_DIV1 = 3'h1,
    CLK_DIV8 = 3'h2,
    CLK_DIV64 = 3'h3,
    CLK_DIV256 = 3'h4,
    CLK_DIV1024 = 3'h5
  } clock_sel_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic write;
    logic read;
  } bus_req_t;

endpackage

// ===== testbench/pin_load.sv
/*
  Pin load model: the port pins that the timer's wave outputs reach.
  Assumes the pins carry a weak pull-down, so an undriven pin reads low.
*/
`timescale 1ns/1ns
module pin_load (
  input wire logic [1:0] i_drive,
  input wire logic [1:0] i_drive_en,
  output logic [1:0] o_level
);
  // Driven only when enabled
  // A released pin falls to the pull-down level, never the last driven value
  assign o_level = i_drive & i_drive_en;
endmodule

// ===== testbench/tb_timer16_ctc_fast_pwm.sv
/*
  Self-checking bench of the 16-bit waveform timer: register reads, flags and pin waveforms.
  Assumes the pin load model and the register map header of the design.
*/
`timescale 1ns/1ns
`include "timer16_regs.svh"
module tb_timer16_ctc_fast_pwm;
  import timer16_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] o_rdata;
  logic [1:0] o_wave_out;
  logic [1:0] o_wave_out_en;
  logic [1:0] pin_level;
  logic [3:0] o_flags;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  logic rd_seen = 1'b0;
  logic [31:0] rnd = 32'h00009A8D;
  logic [15:0] c;
  logic [15:0] e;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int hi;
  int hb;
  int tg;

  always #4 i_clock = ~i_clock;

  timer16_ctc_fast_pwm dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .o_wave_out(o_wave_out), .o_wave_out_en(o_wave_out_en), .o_flags(o_flags));
  pin_load load (.i_drive(o_wave_out), .i_drive_en(o_wave_out_en), .o_level(pin_level));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [15:0] ctl(input logic [3:0] m, input logic [2:0] k,
    input logic [1:0] a, input logic d);
    return {3'h0, d, 2'h0, a, 1'h0, k, m};
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A gap cycle after each strobe keeps every strobe to one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
    exp_q.push_back({exp, m});
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    @(posedge i_clock);
  endtask

  // Windows are whole periods, so high and edge counts do not depend on phase
  task automatic meas(input int n);
    logic last;
    hi = 0;
    hb = 0;
    tg = 0;
    last = pin_level[0];
    repeat (n) begin
      @(posedge i_clock);
      if (pin_level[0] === 1'b1) hi++;
      if (pin_level[1] === 1'b1) hb++;
      if (pin_level[0] !== last) tg++;
      last = pin_level[0];
    end
  endtask

  always @(posedge i_clock) begin
    rd_seen <= i_read;
    if (rd_seen) begin
      note = exp_q.pop_front();
      cmp(o_rdata & note[15:0], note[31:16]);
    end
  end

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    wr(4'hF, 16'hABCD);
    rd(4'hF, 16'h0000, 16'hFFFF);
    rd(`ADDR_CONTROL, `CONTROL_RESET, 16'hFFFF);
    rd(`ADDR_FLAGS, 16'h0000, 16'hFFFF);
    wr(`ADDR_COUNT, 16'h0050);
    wr(`ADDR_CONTROL, ctl(MODE_NORMAL, CLK_DIV1, 2'h0, 1'b0));
    repeat (20) @(posedge i_clock);
    rd(`ADDR_COUNT, 16'h0050, 16'hFFFF);
    wr(`ADDR_COMPARE_A, 16'h0009);
    wr(`ADDR_CAPTURE_TOP, 16'h0009);
    for (int p = 0; p < 2; p++) begin
      wr(`ADDR_CONTROL, ctl(p ? MODE_CTC_CAPT : MODE_CTC_CMPA, CLK_STOP, 2'h0, 1'b0));
      wr(`ADDR_COUNT, 16'h0000);
      wr(`ADDR_FLAGS, 16'h000F);
      wr(`ADDR_CONTROL, ctl(p ? MODE_CTC_CAPT : MODE_CTC_CMPA, CLK_DIV1, 2'h0, 1'b0));
      repeat (50) @(posedge i_clock);
      wr(`ADDR_CONTROL, ctl(p ? MODE_CTC_CAPT : MODE_CTC_CMPA, CLK_STOP, 2'h0, 1'b0));
      rd(`ADDR_COUNT, 16'h0000, 16'hFFF0);
      rd(`ADDR_FLAGS, p ? 16'h000A : 16'h0002, 16'h000B);
    end
    wr(`ADDR_CONTROL, ctl(MODE_CTC_CMPA, CLK_STOP, 2'h0, 1'b0));
    wr(`ADDR_COUNT, 16'hFFF0);
    wr(`ADDR_COMPARE_A, 16'h0005);
    wr(`ADDR_FLAGS, 16'h000F);
    wr(`ADDR_CONTROL, ctl(MODE_CTC_CMPA, CLK_DIV1, 2'h0, 1'b0));
    repeat (40) @(posedge i_clock);
    wr(`ADDR_CONTROL, ctl(MODE_CTC_CMPA, CLK_STOP, 2'h0, 1'b0));
    rd(`ADDR_FLAGS, 16'h0003, 16'h0003);
    wr(`ADDR_COMPARE_A, 16'h0040);
    wr(`ADDR_COUNT, 16'h0040);
    wr(`ADDR_FLAGS, 16'h000F);
    wr(`ADDR_CONTROL, ctl(MODE_CTC_CMPA, CLK_DIV1, 2'h0, 1'b0));
    repeat (5) @(posedge i_clock);
    wr(`ADDR_CONTROL, ctl(MODE_CTC_CMPA, CLK_STOP, 2'h0, 1'b0));
    rd(`ADDR_FLAGS, 16'h0000, 16'h0002);
    wr(`ADDR_COUNT, 16'h0000);
    wr(`ADDR_COMPARE_A, 16'h0003);
    for (int p = 0; p < 2; p++) begin
      wr(`ADDR_CONTROL, ctl(MODE_CTC_CMPA, p ? CLK_DIV8 : CLK_DIV1, 2'h1, 1'b1));
      repeat (80 << (3 * p)) @(posedge i_clock);
      meas(80 << (3 * p));
      cmp(16'(tg), 16'h0014);
    end
    wr(`ADDR_CONTROL, ctl(MODE_CTC_CMPA, CLK_DIV1, 2'h1, 1'b0));
    // The pin register still shows the old direction for one cycle
    repeat (2) @(posedge i_clock);
    meas(80);
    cmp(16'(hi + tg), 16'h0000);
    cmp(16'(o_wave_out_en), 16'h0000);
    wr(`ADDR_CONTROL, ctl(MODE_CTC_CMPA, CLK_DIV1, 2'h0, 1'b1));
    wr(`ADDR_WAVE, 16'h0001);
    repeat (10) @(posedge i_clock);
    cmp(16'(o_wave_out_en), 16'h0001);
    meas(80);
    cmp(16'(hi), 16'h0050);
    rd(`ADDR_WAVE, 16'h0001, 16'h0001);
    for (int p = 0; p < 3; p++) begin
      wr(`ADDR_CONTROL, ctl(4'(MODE_FAST_8 + p), CLK_STOP, 2'h0, 1'b0));
      wr(`ADDR_COMPARE_A, 16'hFFFF);
      rd(`ADDR_COMPARE_A, (16'h0100 << p) - 16'h0001, 16'hFFFF);
    end
    wr(`ADDR_CONTROL, ctl(MODE_FAST_CAPT, CLK_STOP, 2'h2, 1'b1));
    wr(`ADDR_COUNT, 16'h0000);
    wr(`ADDR_CAPTURE_TOP, 16'h000F);
    for (int k = 0; k < 5; k++) begin
      rnd = xs(rnd);
      c = (k == 0) ? 16'h0000 : (k == 1) ? 16'h000F : 16'(rnd % 15);
      for (int a = 2; a < 4; a++) begin
        e = (c == 16'h000F) ? 16'h0000 : 16'((c + 1) * 10);
        if (a == 3) e = 16'h00A0 - e;
        wr(`ADDR_COMPARE_A, c);
        wr(`ADDR_CONTROL, ctl(MODE_FAST_CAPT, CLK_DIV1, 2'(a), 1'b1));
        repeat (48) @(posedge i_clock);
        meas(160);
        cmp(16'(hi), e);
      end
    end
    wr(`ADDR_CONTROL, ctl(MODE_FAST_CMPA, CLK_STOP, 2'h1, 1'b1));
    wr(`ADDR_COUNT, 16'h0000);
    wr(`ADDR_COMPARE_A, 16'h0007);
    wr(`ADDR_CONTROL, ctl(MODE_FAST_CMPA, CLK_DIV1, 2'h1, 1'b1));
    repeat (48) @(posedge i_clock);
    meas(160);
    cmp(16'(hi), 16'h0050);
    cmp(16'(tg), 16'h0014);
    wr(`ADDR_CONTROL, ctl(MODE_FAST_CMPA, CLK_STOP, 2'h1, 1'b1));
    wr(`ADDR_COUNT, 16'h0005);
    // A top below the count only works if the write waits in the buffer
    wr(`ADDR_COMPARE_A, 16'h0003);
    wr(`ADDR_FLAGS, 16'h000F);
    wr(`ADDR_CONTROL, ctl(MODE_FAST_CMPA, CLK_DIV1, 2'h1, 1'b1));
    repeat (20) @(posedge i_clock);
    wr(`ADDR_CONTROL, ctl(MODE_FAST_CMPA, CLK_STOP, 2'h1, 1'b1));
    rd(`ADDR_FLAGS, 16'h0003, 16'h0003);
    wr(`ADDR_CONTROL, ctl(MODE_FAST_CAPT, CLK_STOP, 2'h2, 1'b1));
    wr(`ADDR_COUNT, 16'hFFF0);
    wr(`ADDR_CAPTURE_TOP, 16'h0010);
    wr(`ADDR_FLAGS, 16'h000F);
    wr(`ADDR_CONTROL, ctl(MODE_FAST_CAPT, CLK_DIV1, 2'h2, 1'b1));
    repeat (6) @(posedge i_clock);
    rd(`ADDR_FLAGS, 16'h0000, 16'h0008);
    repeat (30) @(posedge i_clock);
    rd(`ADDR_FLAGS, 16'h0008, 16'h0008);
    wr(`ADDR_CONTROL, ctl(MODE_FAST_8, CLK_STOP, 2'h2, 1'b1));
    wr(`ADDR_COUNT, 16'h0000);
    wr(`ADDR_COMPARE_A, 16'h007F);
    wr(`ADDR_COMPARE_B, 16'h0010);
    wr(`ADDR_FLAGS, 16'h000F);
    // Channel B runs non-inverting with its pin enabled as well
    wr(`ADDR_CONTROL, ctl(MODE_FAST_8, CLK_DIV1, 2'h2, 1'b1) | 16'h2800);
    repeat (300) @(posedge i_clock);
    meas(512);
    cmp(16'(hi), 16'h0100);
    cmp(16'(hb), 16'h0022);
    wr(`ADDR_CONTROL, ctl(MODE_FAST_8, CLK_STOP, 2'h2, 1'b1));
    rd(`ADDR_FLAGS, 16'h0005, 16'h0005);
    repeat (2) @(posedge i_clock);
    cmp(16'(o_flags & 4'h5), 16'h0005);
    end_of_test();
  end
endmodule
